// ---- periph_bus_model.sv ----
// Peripheral bus register model answering the wait generator
`timescale 1ns/1ps
module periph_bus_model (
  input wire logic core_clk,
  input wire wait_gen_pkg::per_req_t per_req,
  output logic [wait_gen_pkg::DATA_W-1:0] per_rdata
);
  logic [wait_gen_pkg::DATA_W-1:0] junk_q = 8'h3c;
  // Released bus shows a changing pattern, never the last good byte
  always @(posedge core_clk) begin
    junk_q <= ~junk_q ^ 8'h01;
  end
  // Separate slow bus, read data valid while the request is up
  assign per_rdata = (per_req.req && !per_req.write) ?
                     (per_req.addr ^ 8'h5a) : junk_q;
endmodule // periph_bus_model

// ---- periph_wait_gen.sv ----
// Wait generator between the processor bus and the peripheral bus
//
// Behaviour
// RL1: Processor bus requests are passed to a separate peripheral bus port.
// RL2: Peripheral timing is unrelated to the processor, so guarded accesses are retried.
// RL3: A guarded access is repeated on the peripheral bus until its waits end.
// RL4: The processor is stalled while a guarded access is being retried.
// RL5: The stall lasts exactly the computed number of wait cycles.
// RL6: Only receive-buffer reads, converter mode, channel and port writes and result-high reads wait.
// RL7: Converter waits are 2*processor_clock_freq/fad+1, fraction above one half rounded up.
// RL8: The conversion clock divide ratio is selectable from 1 to 12.
// RL9: The count assumes both clocks come from one source clock.
// RL10: All waits are counted in processor clock cycles.
// RL11: Software must not make a waiting access while the peripheral clock is stopped.
// RL12: Any other peripheral access completes with no wait.
`timescale 1ns/1ps
module periph_wait_gen #(
  parameter int CONV_DIV_LIMIT = 12,
  parameter int CPU_SHIFT_LIMIT = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire wait_gen_pkg::cpu_req_t cpu_req,
  input wire logic [wait_gen_pkg::DIV_W-1:0] conv_div,
  input wire logic [wait_gen_pkg::SHIFT_W-1:0] cpu_shift,
  input wire logic [wait_gen_pkg::DATA_W-1:0] per_rdata,
  output wait_gen_pkg::per_req_t per_req_q,
  output logic cpu_stall_q,
  output logic cpu_ack_q,
  output logic [wait_gen_pkg::DATA_W-1:0] cpu_rdata_q
);
  generate
    if (CONV_DIV_LIMIT != 12 || CPU_SHIFT_LIMIT > 4 ||
        CPU_SHIFT_LIMIT < 0) begin : g_bad
      $error("periph_wait_gen: unsupported divider limits");
    end
  endgenerate

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } state_t;

  state_t state_q, state_d;
  logic [wait_gen_pkg::CNT_W-1:0] cnt_q, cnt_d;
  wait_gen_pkg::per_req_t per_req_d;
  logic stall_d, ack_d;
  logic [wait_gen_pkg::DATA_W-1:0] rdata_d;
  logic [wait_gen_pkg::CNT_W-1:0] var_waits, req_waits;
  logic [wait_gen_pkg::DIV_W-1:0] div_sat;
  logic [wait_gen_pkg::SHIFT_W-1:0] shift_sat;
  wait_gen_pkg::wait_kind_t kind;

  // Out-of-range selections are clamped rather than producing a bogus count
  always_comb begin
    div_sat = conv_div;
    if (conv_div < wait_gen_pkg::CONV_DIV_MIN) begin
      div_sat = wait_gen_pkg::CONV_DIV_MIN; // RL8
    end else if (conv_div > wait_gen_pkg::CONV_DIV_MAX) begin
      div_sat = wait_gen_pkg::CONV_DIV_MAX; // RL8
    end
    shift_sat = cpu_shift;
    if (cpu_shift > wait_gen_pkg::CPU_SHIFT_MAX) begin
      shift_sat = wait_gen_pkg::CPU_SHIFT_MAX;
    end
  end

  // Ratio assumes a common source clock, no runtime frequency measurement
  wait_count_calc #(
    .DIV_W(wait_gen_pkg::DIV_W),
    .SHIFT_W(wait_gen_pkg::SHIFT_W),
    .CNT_W(wait_gen_pkg::CNT_W)
  ) u_calc (
    .conv_div(div_sat),
    .cpu_shift(shift_sat),
    .waits(var_waits)
  ); // RL9

  always_comb begin
    kind = wait_gen_pkg::classify(cpu_req.write, cpu_req.addr); // RL6
    case (kind)
      wait_gen_pkg::WAIT_FIXED: req_waits = wait_gen_pkg::UART_RX_WAITS;
      wait_gen_pkg::WAIT_VARIABLE: req_waits = var_waits; // RL7
      default: req_waits = '0; // RL12
    endcase
  end

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    per_req_d = per_req_q;
    per_req_d.req = 1'b0;
    stall_d = 1'b0;
    ack_d = 1'b0;
    rdata_d = cpu_rdata_q;
    case (state_q)
      ST_IDLE: begin
        if (cpu_req.valid) begin
          per_req_d.req = 1'b1; // RL1
          per_req_d.write = cpu_req.write;
          per_req_d.addr = cpu_req.addr;
          per_req_d.wdata = cpu_req.wdata;
          if (req_waits == '0) begin
            ack_d = 1'b1; // RL12
            state_d = ST_DONE;
          end else begin
            cnt_d = req_waits; // RL10
            stall_d = 1'b1; // RL4
            state_d = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        // Data may be torn until the count runs out, so keep re-issuing
        per_req_d.req = 1'b1; // RL3 RL2
        cnt_d = cnt_q - wait_gen_pkg::CNT_W'(1);
        if (cnt_q == wait_gen_pkg::CNT_W'(1)) begin
          ack_d = 1'b1; // RL5
          per_req_d.req = 1'b0;
          state_d = ST_DONE;
        end else begin
          stall_d = 1'b1; // RL4
        end
      end
      ST_DONE: begin
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
    // The request leaves through a flop, so a no-wait read can only be
    // captured in the cycle after its acknowledge
    if (state_q == ST_WAIT && ack_d && !per_req_q.write) begin
      rdata_d = per_rdata; // RL3
    end else if (state_q == ST_DONE && per_req_q.req &&
                 !per_req_q.write) begin
      rdata_d = per_rdata; // RL12
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      per_req_q <= '0;
      cpu_stall_q <= 1'b0;
      cpu_ack_q <= 1'b0;
      cpu_rdata_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      per_req_q <= per_req_d;
      cpu_stall_q <= stall_d;
      cpu_ack_q <= ack_d;
      cpu_rdata_q <= rdata_d;
    end
  end

  // Stall length helper
  logic [wait_gen_pkg::CNT_W:0] stall_len_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stall_len_q <= '0;
    end else if (cpu_stall_q) begin
      stall_len_q <= stall_len_q + (wait_gen_pkg::CNT_W+1)'(1);
    end else begin
      stall_len_q <= '0;
    end
  end

  // Wait count of the access in flight, for the stall length check
  logic [wait_gen_pkg::CNT_W:0] exp_len_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      exp_len_q <= '0;
    end else if (state_q == ST_IDLE && cpu_req.valid) begin
      exp_len_q <= {1'b0, req_waits};
    end
  end

  chk_uart_one_wait: assert property ( // RL6
    @(posedge core_clk) disable iff (!rst_n)
    (state_q == ST_IDLE && cpu_req.valid && !cpu_req.write &&
     cpu_req.addr == wait_gen_pkg::ADDR_UART_RECEIVE_BUFFER)
    |=> cpu_stall_q ##1 (!cpu_stall_q && cpu_ack_q))
    else $error("receive buffer read did not wait exactly one cycle");

  chk_plain_no_wait: assert property ( // RL12
    @(posedge core_clk) disable iff (!rst_n)
    (state_q == ST_IDLE && cpu_req.valid && kind == wait_gen_pkg::WAIT_NONE)
    |=> (cpu_ack_q && !cpu_stall_q))
    else $error("unlisted access was stalled");

  chk_stall_length: assert property ( // RL5
    @(posedge core_clk) disable iff (!rst_n)
    (state_q == ST_IDLE && cpu_req.valid && req_waits != '0)
    |=> (cpu_stall_q && cnt_q == $past(req_waits)))
    else $error("wait count not loaded from request");

  chk_stall_ends_ack: assert property ( // RL5
    @(posedge core_clk) disable iff (!rst_n)
    $fell(cpu_stall_q) |-> (cpu_ack_q && stall_len_q == exp_len_q))
    else $error("stall length differs from wait count");

  chk_retry_held: assert property ( // RL3
    @(posedge core_clk) disable iff (!rst_n)
    (state_q == ST_WAIT && cnt_q > wait_gen_pkg::CNT_W'(1))
    |=> (per_req_q.req && $stable(per_req_q.addr)))
    else $error("guarded access not repeated");

  chk_stall_no_ack: assert property ( // RL4
    @(posedge core_clk) disable iff (!rst_n)
    cpu_stall_q |-> !cpu_ack_q)
    else $error("acknowledge during stall");

  chk_var_formula: assert property ( // RL7
    @(posedge core_clk) disable iff (!rst_n)
    (shift_sat == '0) |->
    (var_waits == wait_gen_pkg::CNT_W'({div_sat, 1'b0}) +
                  wait_gen_pkg::CNT_W'(1)))
    else $error("converter wait count wrong at equal clocks");

  chk_div_range: assert property ( // RL8
    @(posedge core_clk) disable iff (!rst_n)
    (div_sat >= wait_gen_pkg::CONV_DIV_MIN &&
     div_sat <= wait_gen_pkg::CONV_DIV_MAX))
    else $error("conversion divider out of range");

  chk_ack_pulse: assert property ( // RL10
    @(posedge core_clk) disable iff (!rst_n)
    cpu_ack_q |=> !cpu_ack_q)
    else $error("acknowledge longer than one cycle");
endmodule // periph_wait_gen

// ---- periph_wait_gen_tb.sv ----
// Self-checking testbench for the peripheral bus wait generator
`timescale 1ns/1ps
module periph_wait_gen_tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  wait_gen_pkg::cpu_req_t cpu_req = '0;
  logic [wait_gen_pkg::DIV_W-1:0] conv_div = 4'h2;
  logic [wait_gen_pkg::SHIFT_W-1:0] cpu_shift = 3'h0;
  logic [wait_gen_pkg::DATA_W-1:0] per_rdata;
  wait_gen_pkg::per_req_t per_req_q;
  logic cpu_stall_q;
  logic cpu_ack_q;
  logic [wait_gen_pkg::DATA_W-1:0] cpu_rdata_q;
  int failures = 0;
  int tests_run = 0;

  always #25 core_clk = ~core_clk;

  periph_wait_gen DUT (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .cpu_req(cpu_req),
    .conv_div(conv_div),
    .cpu_shift(cpu_shift),
    .per_rdata(per_rdata),
    .per_req_q(per_req_q),
    .cpu_stall_q(cpu_stall_q),
    .cpu_ack_q(cpu_ack_q),
    .cpu_rdata_q(cpu_rdata_q)
  );

  periph_bus_model far_end (
    .core_clk(core_clk),
    .per_req(per_req_q),
    .per_rdata(per_rdata)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Reference wait count: fraction above one half rounds up
  function automatic int ref_waits(input int div, input int shift);
    int den;
    int q;
    den = 1 << shift;
    q = (2 * div) / den;
    if (2 * ((2 * div) % den) > den) begin
      q++;
    end
    return q + 1;
  endfunction

  // One access; valid held until ack, then one idle cycle
  task automatic access(input logic wr, input logic [7:0] addr, input int n);
    int stalls;
    int cyc;
    int ack_at;
    stalls = 0;
    ack_at = 0;
    cpu_req = {1'b1, wr, addr, addr ^ 8'hc3};
    for (cyc = 1; cyc <= 40 && ack_at == 0; cyc++) begin
      @(posedge core_clk);
      #1;
      if (cpu_stall_q === 1'b1) begin
        stalls++;
        check(per_req_q.req, 1);
      end
      if (cpu_ack_q === 1'b1) begin
        ack_at = cyc;
      end
    end
    cpu_req.valid = 1'b0;
    if (ack_at == 0) begin
      failures++;
      summarize();
    end
    check(stalls, n);
    check(ack_at, n + 1);
    check(cpu_stall_q, 0);
    check({per_req_q.write, per_req_q.addr}, {wr, addr});
    @(posedge core_clk);
    #1;
    // Read data stands from the cycle after the acknowledge on
    if (!wr) begin
      check(cpu_rdata_q, addr ^ 8'h5a);
    end
  endtask

  task automatic t_uart;
    conv_div = 4'hc;
    access(1'b0, wait_gen_pkg::ADDR_UART_RECEIVE_BUFFER, 1);
    conv_div = 4'h1;
    access(1'b0, wait_gen_pkg::ADDR_UART_RECEIVE_BUFFER, 1);
    $display("receive buffer test done");
  endtask

  // Sweep every divide ratio and processor shift over all four registers
  task automatic t_conv;
    logic [7:0] regs [4];
    regs = '{wait_gen_pkg::ADDR_CONVERTER_MODE_REG,
             wait_gen_pkg::ADDR_CONVERTER_CHANNEL_SELECT,
             wait_gen_pkg::ADDR_CONVERTER_PORT_CONFIG,
             wait_gen_pkg::ADDR_CONVERTER_RESULT_HIGH};
    for (int d = 1; d <= 12; d++) begin
      for (int s = 0; s <= 4; s++) begin
        conv_div = d[3:0];
        cpu_shift = s[2:0];
        for (int r = 0; r < 4; r++) begin
          access(r != 3, regs[r], ref_waits(d, s));
        end
      end
    end
    $display("converter wait test done");
  endtask

  // Wrong direction on listed registers and an unlisted one: no waits
  task automatic t_plain;
    int n;
    conv_div = 4'hc;
    access(1'b1, wait_gen_pkg::ADDR_UART_RECEIVE_BUFFER, 0);
    access(1'b0, wait_gen_pkg::ADDR_CONVERTER_MODE_REG, 0);
    access(1'b1, wait_gen_pkg::ADDR_CONVERTER_RESULT_HIGH, 0);
    access(1'b0, 8'h40, 0);
    // Out-of-range selections are clamped to the legal end points
    conv_div = 4'h0;
    cpu_shift = 3'h0;
    n = ref_waits(1, 0);
    access(1'b1, wait_gen_pkg::ADDR_CONVERTER_MODE_REG, n);
    conv_div = 4'hf;
    cpu_shift = 3'h7;
    n = ref_waits(12, 4);
    access(1'b1, wait_gen_pkg::ADDR_CONVERTER_MODE_REG, n);
    $display("no wait test done");
  endtask

  // Peripheral clock is never stopped here, so waiting accesses are legal
  initial begin
    repeat (4) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    t_uart();
    t_conv();
    t_plain();
    summarize();
  end
endmodule // periph_wait_gen_tb

// ---- wait_count_calc.sv ----
// Wait count from the processor and conversion clock ratio
`timescale 1ns/1ps
module wait_count_calc #(
  parameter int DIV_W = 4,
  parameter int SHIFT_W = 3,
  parameter int CNT_W = 5
) (
  input wire logic [DIV_W-1:0] conv_div,
  input wire logic [SHIFT_W-1:0] cpu_shift,
  output logic [CNT_W-1:0] waits
);
  // Conversion clock is fPRS/conv_div, processor clock is fPRS>>cpu_shift,
  // so 2*processor_clock_freq/fad = 2*conv_div / 2**cpu_shift.
  logic [DIV_W:0] num;
  logic [DIV_W:0] quo;
  logic [DIV_W:0] rem;
  logic [DIV_W+1:0] rem2;
  logic [DIV_W+1:0] den;
  logic up;
  always_comb begin
    num = {conv_div, 1'b0};
    quo = num >> cpu_shift;
    rem = num - (quo << cpu_shift);
    rem2 = {rem, 1'b0};
    den = (DIV_W+2)'(1) << cpu_shift;
    up = rem2 > den; // RL7
    waits = CNT_W'(quo) + CNT_W'(up) + CNT_W'(1); // RL7
  end
endmodule // wait_count_calc

// ---- wait_gen_pkg.sv ----
// Shared constants and types for the peripheral bus wait generator
package wait_gen_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CNT_W = 5;
  localparam int DIV_W = 4;
  localparam int SHIFT_W = 3;
  localparam logic [DIV_W-1:0] CONV_DIV_MIN = 4'h1;
  localparam logic [DIV_W-1:0] CONV_DIV_MAX = 4'hc;
  localparam logic [SHIFT_W-1:0] CPU_SHIFT_MAX = 3'h4;
  localparam logic [CNT_W-1:0] UART_RX_WAITS = 5'h01;
  // Peripheral register addresses on the peripheral bus
  localparam logic [ADDR_W-1:0] ADDR_UART_RECEIVE_BUFFER = 8'h12;
  localparam logic [ADDR_W-1:0] ADDR_CONVERTER_MODE_REG = 8'h28;
  localparam logic [ADDR_W-1:0] ADDR_CONVERTER_CHANNEL_SELECT = 8'h29;
  localparam logic [ADDR_W-1:0] ADDR_CONVERTER_PORT_CONFIG = 8'h2a;
  localparam logic [ADDR_W-1:0] ADDR_CONVERTER_RESULT_HIGH = 8'h2b;

  typedef enum logic [1:0] {
    WAIT_NONE = 2'h0,
    WAIT_FIXED = 2'h1,
    WAIT_VARIABLE = 2'h2
  } wait_kind_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cpu_req_t;

  typedef struct packed {
    logic req;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } per_req_t;

  function automatic wait_kind_t classify(input logic write,
                                          input logic [ADDR_W-1:0] addr);
    wait_kind_t k;
    k = WAIT_NONE;
    if (!write && addr == ADDR_UART_RECEIVE_BUFFER) begin
      k = WAIT_FIXED;
    end else if (write && (addr == ADDR_CONVERTER_MODE_REG ||
                           addr == ADDR_CONVERTER_CHANNEL_SELECT ||
                           addr == ADDR_CONVERTER_PORT_CONFIG)) begin
      k = WAIT_VARIABLE;
    end else if (!write && addr == ADDR_CONVERTER_RESULT_HIGH) begin
      k = WAIT_VARIABLE;
    end
    return k;
  endfunction
endpackage
